// File: event_flag.v
`timescale 1ns/100ps
// ==========================================
// one sticky status bit; a set in the clear cycle is kept
module event_flag (
	input wire sys_clk,
	input wire resetn,
	input wire set,
	input wire clr,
	input wire en,
	output wire flag,
	output wire active
);
	reg flag_reg;

	// set wins over clear so no event is lost
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flag_reg <= 1'b0;
		end else if (set) begin
			flag_reg <= 1'b1;
		end else if (clr) begin
			flag_reg <= 1'b0;
		end
	end

	assign flag = flag_reg;
	assign active = flag_reg & en;
endmodule

// File: low_power_mode_control.v
// Behaviour
// - writing halt bit enters halt-all once the writing instruction completes
// - halt-all stops internal oscillator, processor, digital peripherals; external oscillator untouched
// - halt-all leaves only by reset; normal reset sequence, fetch from zero
// - enabled clock-loss detector resets the device out of halt-all
// - regulator stays on in halt unless regulator-off bit was set beforehand
// - with regulator off, only the reset pin or power cycle resets
// - writing suspend bit stops processor and fast oscillator after that instruction
// - suspend keeps all registers and memory unchanged
// - in suspend only port match and slow-clocked timer three stay active
// - suspend ends on port match, timer overflow, enabled comparator low, reset
// - non-reset wake resumes at the instruction after the suspend write
// - port-match or timer wake configured for interrupt raises it after waking
// - reset out of suspend runs normal reset sequence from address zero
// - watchdog may be disabled before idle only if configuration permits
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "lpm_regs.vh"
module low_power_mode_control (
	input wire sys_clk,
	input wire resetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire instr_done,
	input wire int_reset_req,
	input wire clock_loss,
	input wire timer3_overflow,
	input wire timer3_slow_clk,
	input wire ext_reset_pin_n,
	input wire port_match_in,
	input wire comparator_in,
	output wire cpu_run,
	output wire hf_osc_en,
	output wire digital_periph_en,
	output wire regulator_en,
	output wire port_match_en,
	output wire timer3_en,
	output wire watchdog_en,
	output wire core_reset,
	output wire [15:0] reset_vector,
	output wire resume_pulse,
	output wire wake_irq_port,
	output wire wake_irq_timer,
	output wire irq
);
	// ==========================================
	// pin synchronisers
	wire ext_rst_n_s;
	wire port_match_s;
	wire cmp_s;

	sync3 #(.RST_VAL(1'b1)) u_sync_rst (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin_in(ext_reset_pin_n),
		.level(ext_rst_n_s)
	);

	sync3 #(.RST_VAL(1'b0)) u_sync_pm (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin_in(port_match_in),
		.level(port_match_s)
	);

	// comparator idles high so no wake is seen out of reset
	sync3 #(.RST_VAL(1'b1)) u_sync_cmp (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin_in(comparator_in),
		.level(cmp_s)
	);

	// ==========================================
	// state and registers
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [3:0] seq_cnt_reg;
	reg [3:0] seq_cnt_next;
	reg halt_req_reg;
	reg suspend_req_reg;
	reg reg_off_reg;
	reg reg_off_latch_reg;
	reg [`WAKE_CFG_W-1:0] wake_cfg_reg;
	reg [`NUM_EV-1:0] irq_en_reg;
	reg [1:0] cause_reg;
	reg resume_reg;
	reg wake_pm_reg;
	reg wake_tmr_reg;
	reg wr_pend_reg;
	reg rd_pend_reg;
	reg [7:0] addr_reg;
	reg [31:0] hrdata_reg;
	reg [31:0] rd_mux;

	wire in_halt = (state_reg == `ST_HALT);
	wire in_susp = (state_reg == `ST_SUSPEND);
	wire in_run = (state_reg == `ST_RUN);
	wire in_rst = (state_reg == `ST_RESET);

	// ==========================================
	// reset sources
	wire pin_rst = ~ext_rst_n_s;
	wire soft_rst = int_reset_req | (clock_loss & wake_cfg_reg[`BIT_CLK_LOSS_EN]);
	wire reg_down = in_halt & reg_off_latch_reg;
	// with the regulator down only the pin gets through
	wire rst_trig = pin_rst | (soft_rst & ~reg_down);

	// ==========================================
	// wake sources
	wire tmr_live = timer3_slow_clk;
	wire wk_port = port_match_s;
	wire wk_tmr = timer3_overflow & tmr_live;
	wire wk_cmp = ~cmp_s & wake_cfg_reg[`BIT_CMP_WAKE];
	wire wake_any = wk_port | wk_tmr | wk_cmp;

	// ==========================================
	// bus decode
	wire addr_ph = hsel & htrans[1] & hready;
	wire wr_now = wr_pend_reg;
	wire wr_pwr = wr_now & (addr_reg == `OFS_POWER_CTRL);
	wire wr_regc = wr_now & (addr_reg == `OFS_REG_CTRL);
	wire wr_osc = wr_now & (addr_reg == `OFS_OSC_CTRL);
	wire wr_cfg = wr_now & (addr_reg == `OFS_WAKE_CFG);
	wire wr_clr = wr_now & (addr_reg == `OFS_IRQ_CLR);
	wire wr_ien = wr_now & (addr_reg == `OFS_IRQ_EN);

	// ==========================================
	// mode sequencer
	always @* begin
		state_next = state_reg;
		seq_cnt_next = seq_cnt_reg;
		case (state_reg)
			`ST_RUN: begin
				if (rst_trig) begin
					state_next = `ST_RESET;
					seq_cnt_next = `RESET_SEQ_CYC;
				end else if (halt_req_reg & instr_done) begin
					state_next = `ST_HALT;
				end else if (suspend_req_reg & instr_done) begin
					state_next = `ST_SUSPEND;
				end
			end
			`ST_HALT: begin
				// nothing but a reset leaves halt
				if (rst_trig) begin
					state_next = `ST_RESET;
					seq_cnt_next = `RESET_SEQ_CYC;
				end
			end
			`ST_SUSPEND: begin
				if (rst_trig) begin
					state_next = `ST_RESET;
					seq_cnt_next = `RESET_SEQ_CYC;
				end else if (wake_any) begin
					state_next = `ST_RUN;
				end
			end
			`ST_RESET: begin
				// count only once every source has let go
				if (rst_trig) begin
					seq_cnt_next = `RESET_SEQ_CYC;
				end else if (seq_cnt_reg != 4'h0) begin
					seq_cnt_next = seq_cnt_reg - 4'h1;
				end else begin
					state_next = `ST_RUN;
				end
			end
			default: begin
				state_next = `ST_RESET;
				seq_cnt_next = `RESET_SEQ_CYC;
			end
		endcase
	end

	// power-up starts with a full reset sequence
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= `ST_RESET;
			seq_cnt_reg <= `RESET_SEQ_CYC;
		end else begin
			state_reg <= state_next;
			seq_cnt_reg <= seq_cnt_next;
		end
	end

	wire enter_halt = in_run & (state_next == `ST_HALT);
	wire enter_susp = in_run & (state_next == `ST_SUSPEND);
	wire leave_susp = in_susp & (state_next == `ST_RUN);
	wire seq_end = in_rst & (state_next == `ST_RUN);

	// ==========================================
	// control registers; mode requests drop when their mode ends
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			halt_req_reg <= 1'b0;
			suspend_req_reg <= 1'b0;
			reg_off_reg <= 1'b0;
			reg_off_latch_reg <= 1'b0;
			wake_cfg_reg <= `WAKE_CFG_RST;
			irq_en_reg <= {`NUM_EV{1'b0}};
		end else begin
			if (in_rst) begin
				halt_req_reg <= 1'b0;
			end else if (wr_pwr & in_run) begin
				halt_req_reg <= hwdata[`BIT_HALT_ALL];
			end
			if (in_rst | leave_susp) begin
				suspend_req_reg <= 1'b0;
			end else if (wr_osc & in_run) begin
				suspend_req_reg <= hwdata[`BIT_SUSPEND];
			end
			if (wr_regc) begin
				reg_off_reg <= hwdata[`BIT_REG_OFF];
			end
			// choice is frozen at halt entry so a late write has no effect
			if (enter_halt) begin
				reg_off_latch_reg <= reg_off_reg;
			end else if (in_rst) begin
				reg_off_latch_reg <= 1'b0;
			end
			if (wr_cfg) begin
				wake_cfg_reg[`BIT_CMP_WAKE] <= hwdata[`BIT_CMP_WAKE];
				wake_cfg_reg[`BIT_CLK_LOSS_EN] <= hwdata[`BIT_CLK_LOSS_EN];
				wake_cfg_reg[`BIT_PM_IRQ] <= hwdata[`BIT_PM_IRQ];
				wake_cfg_reg[`BIT_TMR_IRQ] <= hwdata[`BIT_TMR_IRQ];
				// lock only sets; once set the watchdog cannot be turned off
				wake_cfg_reg[`BIT_WDT_LOCK] <= wake_cfg_reg[`BIT_WDT_LOCK] | hwdata[`BIT_WDT_LOCK];
				if (!wake_cfg_reg[`BIT_WDT_LOCK]) begin
					wake_cfg_reg[`BIT_WDT_EN] <= hwdata[`BIT_WDT_EN];
				end
			end
			if (wr_ien) begin
				irq_en_reg <= hwdata[`NUM_EV-1:0];
			end
		end
	end

	// ==========================================
	// wake cause and wake pulses to the core
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cause_reg <= `CAUSE_NONE;
			resume_reg <= 1'b0;
			wake_pm_reg <= 1'b0;
			wake_tmr_reg <= 1'b0;
		end else begin
			resume_reg <= leave_susp;
			wake_pm_reg <= leave_susp & wk_port & wake_cfg_reg[`BIT_PM_IRQ];
			wake_tmr_reg <= leave_susp & wk_tmr & wake_cfg_reg[`BIT_TMR_IRQ];
			if (leave_susp) begin
				if (wk_port) begin
					cause_reg <= `CAUSE_PORT;
				end else if (wk_tmr) begin
					cause_reg <= `CAUSE_TMR;
				end else begin
					cause_reg <= `CAUSE_CMP;
				end
			end else if (enter_susp | in_rst) begin
				cause_reg <= `CAUSE_NONE;
			end
		end
	end

	// ==========================================
	// sticky events, clear by writing ones
	wire [`NUM_EV-1:0] ev_set;
	wire [`NUM_EV-1:0] ev_flag;
	wire [`NUM_EV-1:0] ev_act;

	assign ev_set[`EV_HALT] = enter_halt;
	assign ev_set[`EV_SUSPEND] = enter_susp;
	assign ev_set[`EV_WAKE_PORT] = leave_susp & wk_port;
	assign ev_set[`EV_WAKE_TMR] = leave_susp & wk_tmr;
	assign ev_set[`EV_WAKE_CMP] = leave_susp & wk_cmp;
	assign ev_set[`EV_RESET] = seq_end;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_EV; gi = gi + 1) begin : g_ev
			event_flag u_flag (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.set(ev_set[gi]),
				.clr(wr_clr & hwdata[gi]),
				.en(irq_en_reg[gi]),
				.flag(ev_flag[gi]),
				.active(ev_act[gi])
			);
		end
	endgenerate

	// ==========================================
	// bus slave: writes land in the data phase, reads add one wait state
	always @* begin
		rd_mux = 32'h00000000;
		case (addr_reg)
			`OFS_POWER_CTRL: rd_mux[`BIT_HALT_ALL] = halt_req_reg;
			`OFS_REG_CTRL: rd_mux[`BIT_REG_OFF] = reg_off_reg;
			`OFS_OSC_CTRL: rd_mux[`BIT_SUSPEND] = suspend_req_reg;
			`OFS_WAKE_CFG: rd_mux[`WAKE_CFG_W-1:0] = wake_cfg_reg;
			`OFS_MODE_STAT: rd_mux[5:0] = {reg_off_latch_reg, cause_reg, ~ext_rst_n_s, state_reg};
			`OFS_IRQ_STAT: rd_mux[`NUM_EV-1:0] = ev_flag;
			`OFS_IRQ_EN: rd_mux[`NUM_EV-1:0] = irq_en_reg;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// the wait state lets a write just before a read land first
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= addr_ph & hwrite;
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				hrdata_reg <= rd_mux;
			end else begin
				rd_pend_reg <= addr_ph & ~hwrite;
			end
			if (addr_ph) begin
				addr_reg <= {haddr[7:2], 2'b00};
			end
		end
	end

	assign hreadyout = ~rd_pend_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// ==========================================
	// power and clock enables decoded from the mode
	// registers are never cleared in suspend, only clocks are gated
	assign cpu_run = in_run;
	assign hf_osc_en = ~(in_halt | in_susp);
	assign digital_periph_en = in_run | in_rst;
	assign regulator_en = ~reg_down;
	assign port_match_en = in_run | in_susp;
	assign timer3_en = in_run | (in_susp & tmr_live);
	assign watchdog_en = wake_cfg_reg[`BIT_WDT_EN];
	assign core_reset = in_rst;
	assign reset_vector = `RESET_VECTOR;
	assign resume_pulse = resume_reg;
	assign wake_irq_port = wake_pm_reg;
	assign wake_irq_timer = wake_tmr_reg;
	assign irq = |ev_act;
endmodule

// File: lpm_checker_assertions.sv
`timescale 1ns/100ps
// ==========================================
// mode output checks
module lpm_checker (
	input logic sys_clk,
	input logic resetn,
	input logic instr_done,
	input logic timer3_slow_clk,
	input logic cpu_run,
	input logic hf_osc_en,
	input logic digital_periph_en,
	input logic regulator_en,
	input logic port_match_en,
	input logic timer3_en,
	input logic core_reset,
	input logic resume_pulse,
	input logic wake_irq_port,
	input logic wake_irq_timer
);
	// one domain, so clock and reset are given once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// run, reset and low power states
	stop_clocks_a:
		assert property (!hf_osc_en |-> !cpu_run && !digital_periph_en) else $error("osc off, core on");
	run_all_on_a:
		assert property (cpu_run |-> hf_osc_en && digital_periph_en && port_match_en && timer3_en && !core_reset)
		else $error("run state outputs wrong");
	enter_after_instr_a:
		assert property ($fell(cpu_run) && !core_reset |-> $past(instr_done)) else $error("early stop");
	suspend_timer_a:
		assert property (!hf_osc_en && port_match_en |-> timer3_en == timer3_slow_clk) else $error("timer gate");
	halt_stay_a:
		assert property (!hf_osc_en && !port_match_en |=> !hf_osc_en || core_reset) else $error("halt left");
	reg_off_halt_a:
		assert property (!regulator_en |-> !hf_osc_en && !port_match_en && !core_reset) else $error("reg off");
	reset_state_a:
		assert property (core_reset |-> !cpu_run && hf_osc_en && digital_periph_en) else $error("reset outs");
	resume_once_a:
		assert property (resume_pulse |-> cpu_run ##1 !resume_pulse) else $error("resume pulse");
	wake_irq_a:
		assert property (wake_irq_port || wake_irq_timer |-> resume_pulse) else $error("stray wake irq");
endmodule
bind low_power_mode_control lpm_checker lpm_checker_i (.sys_clk, .resetn, .instr_done, .timer3_slow_clk,
	.cpu_run, .hf_osc_en, .digital_periph_en, .regulator_en, .port_match_en, .timer3_en, .core_reset,
	.resume_pulse, .wake_irq_port, .wake_irq_timer);

// File: lpm_regs.vh
`ifndef LPM_REGS_VH
`define LPM_REGS_VH
// ==========================================
// register offsets (byte addresses)
`define OFS_POWER_CTRL 8'h00
`define OFS_REG_CTRL 8'h04
`define OFS_OSC_CTRL 8'h08
`define OFS_WAKE_CFG 8'h0C
`define OFS_MODE_STAT 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_IRQ_EN 8'h1C
// ==========================================
// field positions
`define BIT_HALT_ALL 1
`define BIT_REG_OFF 0
`define BIT_SUSPEND 5
`define BIT_CMP_WAKE 0
`define BIT_CLK_LOSS_EN 1
`define BIT_WDT_EN 2
`define BIT_WDT_LOCK 3
`define BIT_PM_IRQ 4
`define BIT_TMR_IRQ 5
`define WAKE_CFG_W 6
// ==========================================
// event bits of the interrupt registers
`define EV_HALT 0
`define EV_SUSPEND 1
`define EV_WAKE_PORT 2
`define EV_WAKE_TMR 3
`define EV_WAKE_CMP 4
`define EV_RESET 5
`define NUM_EV 6
// ==========================================
// mode states and wake causes
`define ST_RUN 2'h0
`define ST_HALT 2'h1
`define ST_SUSPEND 2'h2
`define ST_RESET 2'h3
`define CAUSE_NONE 2'h0
`define CAUSE_PORT 2'h1
`define CAUSE_TMR 2'h2
`define CAUSE_CMP 2'h3
// ==========================================
// reset values and timing
`define WAKE_CFG_RST 6'h06
`define RESET_VECTOR 16'h0000
`define RESET_SEQ_CYC 4'h4
`endif

// File: sync3.v
`timescale 1ns/100ps
// ==========================================
// three-stage pin synchroniser; output moves once stages two and three agree
module sync3 #(
	parameter RST_VAL = 1'b0
) (
	input wire sys_clk,
	input wire resetn,
	input wire pin_in,
	output wire level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg level_reg;

	// first stage feeds only the second stage
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			level_reg <= RST_VAL;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_reg <= s3_reg;
			end
		end
	end

	assign level = level_reg;
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
`include "lpm_regs.vh"
module tb_top;
	logic sys_clk, resetn, hsel, hwrite, instr_done, int_reset_req, clock_loss, timer3_overflow;
	logic timer3_slow_clk, ext_reset_pin_n, port_match_in, comparator_in, ip, it;
	logic [31:0] haddr, hwdata, rdat;
	logic [1:0] htrans;
	wire hreadyout, hresp, cpu_run, hf_osc_en, digital_periph_en, regulator_en, port_match_en, timer3_en;
	wire watchdog_en, core_reset, resume_pulse, wake_irq_port, wake_irq_timer, irq;
	wire [31:0] hrdata;
	wire [15:0] reset_vector;
	integer num_errors, check_count, k;
	// the one slave drives the bus ready
	low_power_mode_control low_power_mode_control_i (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instr_done, .int_reset_req,
		.clock_loss, .timer3_overflow, .timer3_slow_clk, .ext_reset_pin_n, .port_match_in, .comparator_in,
		.cpu_run, .hf_osc_en, .digital_periph_en, .regulator_en, .port_match_en, .timer3_en, .watchdog_en,
		.core_reset, .reset_vector, .resume_pulse, .wake_irq_port, .wake_irq_timer, .irq);
	// ==========================================
	// report helpers
	task end_of_test;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task bail;
		begin
			num_errors = num_errors + 1;
			$display("BAD %0t wait ran out", $time);
			end_of_test;
		end
	endtask
	// ==========================================
	// bus master
	// edges until ready is sampled high; bounded so a dead slave ends the run
	task rdy;
		integer n;
		begin
			n = 0;
			@(posedge sys_clk);
			while (hreadyout !== 1'b1) begin
				n = n + 1;
				if (n > 20)
					bail;
				@(posedge sys_clk);
			end
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= {24'h0, a};
			htrans <= 2'h2;
			hwrite <= w;
			rdy;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			rdy;
			rdat = hrdata;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		begin
			xfer(1'b0, a, 32'h0);
			chk(rdat, e);
		end
	endtask
	// ==========================================
	// core side
	// one completed instruction, then let its effect land
	task step;
		begin
			instr_done <= 1'b1;
			@(posedge sys_clk);
			instr_done <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	// s selects the awaited signal: 0 core running, 1 resume pulse
	task wait_for(input integer s);
		integer n;
		begin
			n = 0;
			@(posedge sys_clk);
			while ((s ? resume_pulse : cpu_run) !== 1'b1) begin
				n = n + 1;
				if (n > 40)
					bail;
				@(posedge sys_clk);
			end
			ip = wake_irq_port;
			it = wake_irq_timer;
		end
	endtask
	// ==========================================
	// scenarios
	task s_regs;
		begin
			rd(`OFS_WAKE_CFG, 32'h06);
			rd(`OFS_IRQ_EN, 32'h0);
			xfer(1'b1, 8'h20, 32'hFFFFFFFF);
			rd(8'h20, 32'h0);
			chk(hresp, 0);
		end
	endtask
	// k: 0 internal reset, 1 clock loss, 2 regulator off with refused reset then pin,
	// 3 clock loss with the detector switched off first, so only the pin ends the halt
	task s_halt(input integer k);
		begin
			xfer(1'b1, `OFS_REG_CTRL, k == 2);
			// a long halt must not be cut short by the clock-loss detector
			if (k == 3)
				xfer(1'b1, `OFS_WAKE_CFG, 32'h04);
			xfer(1'b1, `OFS_POWER_CTRL, 32'h2);
			step;
			chk(cpu_run, 0);
			chk({hf_osc_en, digital_periph_en}, 0);
			chk(regulator_en, k != 2);
			int_reset_req <= (k == 0 || k == 2);
			clock_loss <= (k == 1 || k == 3);
			repeat (8) @(posedge sys_clk);
			chk(core_reset, k < 2);
			chk(cpu_run, 0);
			ext_reset_pin_n <= (k < 2);
			repeat (8) @(posedge sys_clk);
			chk(core_reset, 1);
			int_reset_req <= 1'b0;
			clock_loss <= 1'b0;
			ext_reset_pin_n <= 1'b1;
			wait_for(0);
			chk(reset_vector, 0);
			rd(`OFS_POWER_CTRL, 32'h0);
		end
	endtask
	// k: 0 port match, 1 timer overflow, 2 comparator low
	task s_susp(input integer k);
		begin
			timer3_slow_clk <= (k == 1);
			xfer(1'b1, `OFS_OSC_CTRL, 32'h20);
			step;
			chk({cpu_run, hf_osc_en, digital_periph_en, port_match_en}, 4'h1);
			chk(timer3_en, k == 1);
			port_match_in <= (k == 0);
			timer3_overflow <= (k == 1);
			comparator_in <= (k != 2);
			wait_for(1);
			chk(cpu_run, 1);
			chk({ip, it}, {k == 0, k == 1});
			port_match_in <= 1'b0;
			timer3_overflow <= 1'b0;
			comparator_in <= 1'b1;
			xfer(1'b0, `OFS_MODE_STAT, 32'h0);
			chk(rdat[4:0], (k + 1) << 3);
			rd(`OFS_WAKE_CFG, 32'h37);
			rd(`OFS_OSC_CTRL, 32'h0);
		end
	endtask
	task s_irq;
		begin
			rd(`OFS_IRQ_STAT, 32'h3F);
			chk(irq, 0);
			xfer(1'b1, `OFS_IRQ_EN, 32'h2);
			repeat (2) @(posedge sys_clk);
			chk(irq, 1);
			xfer(1'b1, `OFS_IRQ_CLR, 32'h2);
			repeat (2) @(posedge sys_clk);
			chk(irq, 0);
			rd(`OFS_IRQ_STAT, 32'h3D);
		end
	endtask
	// lock is sticky, so a later disable must be refused
	task s_wdt;
		begin
			xfer(1'b1, `OFS_WAKE_CFG, 32'h33);
			@(posedge sys_clk);
			chk(watchdog_en, 0);
			xfer(1'b1, `OFS_WAKE_CFG, 32'h3F);
			xfer(1'b1, `OFS_WAKE_CFG, 32'h33);
			@(posedge sys_clk);
			chk(watchdog_en, 1);
		end
	endtask
	// ==========================================
	// clock and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		{num_errors, check_count} = 0;
		{resetn, hsel, hwrite, instr_done, int_reset_req, clock_loss, timer3_overflow} = 0;
		{timer3_slow_clk, port_match_in, haddr, hwdata, htrans} = 0;
		{ext_reset_pin_n, comparator_in} = 2'h3;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		wait_for(0);
		s_regs;
		for (k = 0; k < 4; k = k + 1)
			s_halt(k);
		xfer(1'b1, `OFS_WAKE_CFG, 32'h37);
		for (k = 0; k < 3; k = k + 1)
			s_susp(k);
		s_irq;
		s_wdt;
		end_of_test;
	end
endmodule
